//--- logic/pwm_cmd_ctrl.sv
/*
 * timer command and fault control with an axi4-lite register slave.
 * assumes a single clock aclk; the fault pins are asynchronous.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwm_cmd_ctrl #(
    parameter int PRESCALE_W = 16,
    parameter int COUNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic write_protect,
    input wire logic [1:0] recov_fault_in,
    input wire logic [1:0] nonrecov_fault_in,
    output logic [3:0] compare_out,
    output logic dma_trigger,
    output logic irq
);
    import pwm_cmd_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] sync1_ff, sync2_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end
        else
        begin
            sync1_ff <= {nonrecov_fault_in, recov_fault_in};
            sync2_ff <= sync1_ff;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    ctrlb_t ctrlb_ff;
    logic [3:0] fault_ctrl_ff;
    drv_ctrl_t drv_ff;
    logic [1:0] evact_ff;
    logic [IRQ_BITS-1:0] int_status_ff, int_mask_ff;
    logic [PRESCALE_W-1:0] prescale_ff;
    logic [COUNT_W-1:0] count_ff, period_ff, count_snap_ff;
    logic stop_ff, ramp_ff, running_ff, nrf_ff;
    logic [1:0] rfault_ff;
    logic tick;
    logic [1:0] nrf_filt;

    prescaler #(.WIDTH(PRESCALE_W)) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .divide(prescale_ff),
        .tick(tick)
    );

    for (genvar g = 0; g < 2; g++)
    begin : g_filter
        fault_filter u_filter (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick),
            .filter_value(drv_ff.filter_value),
            .raw(sync2_ff[2+g]),
            .filtered(nrf_filt[g])
        );
    end

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    logic [7:0] awaddr_ff;
    logic aw_got_ff, w_got_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go, wr_hit;
    assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            OFS_CTRLB_CLEAR, OFS_CTRLB_SET, OFS_STATUS, OFS_FAULT_CTRL,
            OFS_DRIVER_CTRL, OFS_EVENT_CTRL, OFS_INT_STATUS, OFS_INT_MASK,
            OFS_PRESCALE, OFS_COUNT, OFS_PERIOD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // status, interrupt status, count and period stay writable under write protection
    function automatic logic guarded(input logic [7:0] a);
        case (a)
            OFS_STATUS, OFS_INT_STATUS, OFS_COUNT, OFS_PERIOD:
                guarded = 1'b0;
            default: guarded = 1'b1;
        endcase
    endfunction : guarded

    assign wr_hit = wr_go && mapped(awaddr_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_got_ff && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_got_ff && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // protected or unmapped writes answer slverr
                s_axi_bresp <= (!mapped(awaddr_ff) || (write_protect &&
                    guarded(awaddr_ff))) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_ok;
    logic [7:0] wb;
    assign wr_ok = wr_hit && wstrb_ff[0] &&
        !(write_protect && guarded(awaddr_ff));
    assign wb = wdata_ff[7:0];

    // ---------------------------------------------------------------
    // control b and command execution
    // ---------------------------------------------------------------
    logic set_wr, clr_wr, ovf, upd_cond;
    assign set_wr = wr_ok && awaddr_ff == OFS_CTRLB_SET;
    assign clr_wr = wr_ok && awaddr_ff == OFS_CTRLB_CLEAR;
    assign ovf = tick && running_ff && (ctrlb_ff.dir ?
        count_ff == '0 : count_ff == period_ff);
    assign upd_cond = ovf || (tick && ctrlb_ff.cmd == CMD_UPDATE);

    logic halt_req;
    assign halt_req = (fault_ctrl_ff[1:0] == HALT_SW && rfault_ff[0]) ||
        (fault_ctrl_ff[3:2] == HALT_SW && rfault_ff[1]) || nrf_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrlb_ff <= ctrlb_t'(CTRLB_RESET);
            dma_trigger <= 1'b0;
            count_snap_ff <= '0;
        end
        else
        begin
            dma_trigger <= 1'b0;
            if (tick && ctrlb_ff.cmd != CMD_NONE)
            begin
                ctrlb_ff.cmd <= CMD_NONE;
                if (ctrlb_ff.cmd == CMD_COUNT_READ_SYNC)
                    count_snap_ff <= count_ff;
                if (ctrlb_ff.cmd == CMD_DMA_TRIGGER)
                    dma_trigger <= 1'b1;
            end
            if (upd_cond && !ctrlb_ff.lock_buffer_update)
                ctrlb_ff.ramp_cmd <= RAMP_TOGGLE;
            if (set_wr)
            begin
                if (wb[7:5] != 3'h0)
                    ctrlb_ff.cmd <= wb[7:5];
                if (wb[4:3] != 2'h0)
                    ctrlb_ff.ramp_cmd <= wb[4:3];
                ctrlb_ff.single_run <=
                    ctrlb_ff.single_run | wb[CB_SINGLE_RUN];
                ctrlb_ff.lock_buffer_update <=
                    ctrlb_ff.lock_buffer_update | wb[CB_LOCK_UPDATE];
                ctrlb_ff.dir <= ctrlb_ff.dir | wb[CB_DIR];
            end
            if (clr_wr)
            begin
                if (wb[7:5] != 3'h0)
                    ctrlb_ff.cmd <= CMD_NONE;
                if (wb[4:3] != 2'h0)
                    ctrlb_ff.ramp_cmd <= RAMP_TOGGLE;
                if (wb[CB_SINGLE_RUN])
                    ctrlb_ff.single_run <= 1'b0;
                if (wb[CB_LOCK_UPDATE])
                    ctrlb_ff.lock_buffer_update <= 1'b0;
                if (wb[CB_DIR])
                    ctrlb_ff.dir <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // counter, stop flag, ramp index
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_ff <= '0;
            running_ff <= 1'b1;
            stop_ff <= 1'b0;
            ramp_ff <= 1'b0;
        end
        else
        begin
            if (tick && ctrlb_ff.cmd == CMD_STOP)
            begin
                running_ff <= 1'b0;
                stop_ff <= 1'b1;
            end
            else if (tick && ctrlb_ff.cmd == CMD_RETRIGGER && !halt_req)
            begin
                running_ff <= 1'b1;
                count_ff <= ctrlb_ff.dir ? period_ff : '0;
            end
            else if (ovf && ctrlb_ff.single_run)
            begin
                running_ff <= 1'b0;
                stop_ff <= 1'b1;
            end
            else if (tick && running_ff && !halt_req)
            begin
                stop_ff <= 1'b0;
                if (ovf)
                    count_ff <= ctrlb_ff.dir ? period_ff : '0;
                else
                    count_ff <= ctrlb_ff.dir ? count_ff - 1'b1
                                             : count_ff + 1'b1;
            end
            if (wr_ok && awaddr_ff == OFS_COUNT)
                count_ff <= wdata_ff[COUNT_W-1:0];
            if (upd_cond)
            begin
                case (ctrlb_ff.ramp_cmd)
                    RAMP_SET: ramp_ff <= 1'b1;
                    RAMP_CLEAR: ramp_ff <= 1'b0;
                    RAMP_HOLD: ramp_ff <= ramp_ff;
                    default: ramp_ff <= !ramp_ff;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // faults and output forcing
    // ---------------------------------------------------------------
    logic [1:0] nrf_act;
    assign nrf_act = nrf_filt & evact_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rfault_ff <= 2'h0;
            nrf_ff <= 1'b0;
            compare_out <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                // set wins over software clear
                if (tick && sync2_ff[i])
                    rfault_ff[i] <= 1'b1;
                else if (wr_ok && awaddr_ff == OFS_STATUS &&
                         wb[ST_RECOV0+i])
                    rfault_ff[i] <= 1'b0;
            end
            if (tick && nrf_act != 2'h0)
                nrf_ff <= 1'b1;
            else if (wr_ok && awaddr_ff == OFS_STATUS && wb[ST_NRF])
                nrf_ff <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                if (nrf_ff && drv_ff.nonrecov_output_enable[i])
                    compare_out[i] <= drv_ff.nonrecov_output_value[i];
                else
                    compare_out[i] <= running_ff && !ramp_ff ?
                        count_ff < (period_ff >> 1) : 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // config registers and interrupts
    // ---------------------------------------------------------------
    logic [IRQ_BITS-1:0] events;
    assign events = {tick && nrf_act != 2'h0,
        tick && (sync2_ff[1:0] != 2'h0), tick && ctrlb_ff.cmd == CMD_STOP,
        ovf};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_ctrl_ff <= 4'h0;
            drv_ff <= '0;
            evact_ff <= 2'h0;
            int_mask_ff <= '0;
            int_status_ff <= '0;
            prescale_ff <= PRESCALE_RESET;
            period_ff <= PERIOD_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_ok && awaddr_ff == OFS_FAULT_CTRL)
                fault_ctrl_ff <= wb[3:0];
            if (wr_ok && awaddr_ff == OFS_DRIVER_CTRL)
                drv_ff <= wdata_ff[11:0];
            if (wr_ok && awaddr_ff == OFS_EVENT_CTRL)
                evact_ff <= wb[1:0];
            if (wr_ok && awaddr_ff == OFS_INT_MASK)
                int_mask_ff <= wb[IRQ_BITS-1:0];
            if (wr_ok && awaddr_ff == OFS_PRESCALE)
                prescale_ff <= wdata_ff[PRESCALE_W-1:0];
            if (wr_ok && awaddr_ff == OFS_PERIOD)
                period_ff <= wdata_ff[COUNT_W-1:0];
            // new events win over write-one-to-clear
            int_status_ff <= (int_status_ff & ~((wr_ok &&
                awaddr_ff == OFS_INT_STATUS) ? wb[IRQ_BITS-1:0] : '0))
                | events;
            irq <= |(int_status_ff & int_mask_ff);
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    logic [7:0] st;
    assign st = {3'h0, nrf_ff, rfault_ff, ramp_ff, stop_ff};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                OFS_CTRLB_CLEAR, OFS_CTRLB_SET:
                    s_axi_rdata <= {24'h0, ctrlb_ff};
                OFS_STATUS: s_axi_rdata <= {24'h0, st};
                OFS_FAULT_CTRL: s_axi_rdata <= {28'h0, fault_ctrl_ff};
                OFS_DRIVER_CTRL: s_axi_rdata <= {20'h0, drv_ff};
                OFS_EVENT_CTRL: s_axi_rdata <= {30'h0, evact_ff};
                OFS_INT_STATUS: s_axi_rdata <= {28'h0, int_status_ff};
                OFS_INT_MASK: s_axi_rdata <= {28'h0, int_mask_ff};
                OFS_PRESCALE: s_axi_rdata <=
                    {{(32-PRESCALE_W){1'b0}}, prescale_ff};
                OFS_COUNT: s_axi_rdata <=
                    {{(32-COUNT_W){1'b0}}, count_snap_ff};
                OFS_PERIOD: s_axi_rdata <= {{(32-COUNT_W){1'b0}}, period_ff};
                default: s_axi_rdata <= 32'h0;
            endcase
        end
        else
        begin
            s_axi_arready <= !s_axi_arready;
        end
    end
endmodule : pwm_cmd_ctrl
`default_nettype wire

//--- logic/pwm_cmd_pkg.sv
/*
 * constants, register offsets and carrier types for the timer command
 * and fault control block.
 * assumes nothing of its surroundings beyond a 32-bit register bus.
 */
package pwm_cmd_pkg;
    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRLB_CLEAR = 8'h04;
    localparam logic [7:0] OFS_CTRLB_SET = 8'h05 << 2;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FAULT_CTRL = 8'h0c;
    localparam logic [7:0] OFS_DRIVER_CTRL = 8'h18;
    localparam logic [7:0] OFS_EVENT_CTRL = 8'h1c;
    localparam logic [7:0] OFS_INT_STATUS = 8'h20;
    localparam logic [7:0] OFS_INT_MASK = 8'h24;
    localparam logic [7:0] OFS_PRESCALE = 8'h28;
    localparam logic [7:0] OFS_COUNT = 8'h2c;
    localparam logic [7:0] OFS_PERIOD = 8'h30;

    // ---------------------------------------------------------------
    // control b field positions
    // ---------------------------------------------------------------
    localparam int CB_DIR = 0;
    localparam int CB_LOCK_UPDATE = 1;
    localparam int CB_SINGLE_RUN = 2;
    localparam int CB_RAMP_LO = 3;
    localparam int CB_CMD_LO = 5;
    localparam logic [7:0] CTRLB_RESET = 8'h00;

    // status bits
    localparam int ST_STOP = 0;
    localparam int ST_RAMP = 1;
    localparam int ST_RECOV0 = 2;
    localparam int ST_RECOV1 = 3;
    localparam int ST_NRF = 4;

    // interrupt event bits
    localparam int IRQ_BITS = 4;
    localparam int EV_OVF = 0;
    localparam int EV_STOP = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_NRF = 3;

    localparam logic [1:0] HALT_SW = 2'h2;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_RETRIGGER = 3'h1,
        CMD_STOP = 3'h2,
        CMD_UPDATE = 3'h3,
        CMD_COUNT_READ_SYNC = 3'h4,
        CMD_DMA_TRIGGER = 3'h5
    } timer_cmd_t;

    typedef enum logic [1:0] {
        RAMP_TOGGLE = 2'h0,
        RAMP_SET = 2'h1,
        RAMP_CLEAR = 2'h2,
        RAMP_HOLD = 2'h3
    } ramp_cmd_t;

    typedef struct packed {
        logic [2:0] cmd;
        logic [1:0] ramp_cmd;
        logic single_run;
        logic lock_buffer_update;
        logic dir;
    } ctrlb_t;

    typedef struct packed {
        logic [3:0] filter_value;
        logic [3:0] nonrecov_output_value;
        logic [3:0] nonrecov_output_enable;
    } drv_ctrl_t;
endpackage : pwm_cmd_pkg

//--- logic/fault_filter.sv
/*
 * digital glitch filter for one non-recoverable fault input.
 * assumes the input is already synchronised to aclk.
 */
`timescale 1ns/10ps
`default_nettype none
module fault_filter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic [3:0] filter_value,
    input wire logic raw,
    output logic filtered
);
    logic [3:0] cnt_ff;
    logic filt_ff;

    // input must hold stable for filter_value ticks to pass
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= 4'h0;
            filt_ff <= 1'b0;
        end
        else if (filter_value == 4'h0)
        begin
            cnt_ff <= 4'h0;
            filt_ff <= raw;
        end
        else if (raw == filt_ff)
        begin
            cnt_ff <= 4'h0;
        end
        else if (tick)
        begin
            if (cnt_ff >= filter_value - 4'h1)
            begin
                cnt_ff <= 4'h0;
                filt_ff <= raw;
            end
            else
            begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    assign filtered = filt_ff;
endmodule : fault_filter
`default_nettype wire

//--- logic/prescaler.sv
/*
 * prescaler: makes the one-cycle counter tick enable from aclk.
 * assumes divide is stable while running; 0 means every cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module prescaler #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] divide,
    output logic tick
);
    logic [WIDTH-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (cnt_ff >= divide)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule : prescaler
`default_nettype wire

//--- verification/pwm_cmd_ctrl_asserts.sv
/* checker: bus handshake, pulse and reset properties of pwm_cmd_ctrl.
   assumes it is bound to the top module; one clock aclk. */
`timescale 1ns/10ps
`default_nettype none
module pwm_cmd_ctrl_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] compare_out,
    input wire logic dma_trigger,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_wr_answer;
        s_wr_taken |-> ##[1:6] s_axi_bvalid;
    endproperty
    property p_dma_pulse;
        dma_trigger |=> !dma_trigger;
    endproperty
    property p_reset_out;
        $rose(aresetn) |-> compare_out == 4'h0 && !irq && !s_axi_bvalid;
    endproperty
    property p_rvalid_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready);
    endproperty
    property p_bvalid_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_wready, 2) ||
            $past(s_axi_awready, 2);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("rd late");
    a_rd_hold: assert property (p_rd_hold) else $error("rd drop");
    a_wr_hold: assert property (p_wr_hold) else $error("wr drop");
    a_wr_answer: assert property (p_wr_answer) else $error("wr late");
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma long");
    a_reset_out: assert property (p_reset_out) else $error("rst out");
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("rv");
    a_bvalid_cause: assert property (p_bvalid_cause) else $error("bv");
endmodule : pwm_cmd_ctrl_asserts
bind pwm_cmd_ctrl pwm_cmd_ctrl_asserts u_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .compare_out, .dma_trigger, .irq);
`default_nettype wire

//--- verification/pwm_timer_command_and_fault_control_bench.sv
/* bench: register, command, fault and irq scenarios for pwm_cmd_ctrl.
   assumes the package and design files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_command_and_fault_control_bench;
    import pwm_cmd_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, write_protect = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, e;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, a, b;
    logic [3:0] s_axi_wstrb = 4'hf, compare_out;
    logic [1:0] recov_fault_in = 2'h0, nonrecov_fault_in = 2'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, dma_trigger, irq;
    int error_cnt = 0, total_checks = 0, dma_cnt = 0, i, seed = 32'hec02;
    pwm_cmd_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_protect,
        .recov_fault_in, .nonrecov_fault_in, .compare_out, .dma_trigger,
        .irq);
    always #20 aclk = ~aclk;
    always @(posedge aclk) if (dma_trigger) dma_cnt++;
    function automatic logic [7:0] ctl(input logic [7:0] o, s, c);
        return (o | s) & ~c;
    endfunction : ctl
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!s_axi_bvalid)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!s_axi_rvalid)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic snap(output logic [31:0] c);
        wr(OFS_CTRLB_SET, 32'h80);
        cyc(4);
        rd(OFS_COUNT);
        c = v;
    endtask : snap
    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial
    begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTRLB_SET);
        chk(v, CTRLB_RESET);
        e = 8'h00;
        for (i = 0; i < 8; i++)
        begin
            a = $random(seed) & 32'h77;
            wr(OFS_CTRLB_SET, a[2:0]);
            wr(OFS_CTRLB_CLEAR, a[6:4]);
            e = ctl(e, a[2:0], a[6:4]);
            rd(OFS_CTRLB_CLEAR);
            chk(v, e);
        end
        wr(OFS_CTRLB_CLEAR, 32'h07);
        for (i = 1; i < 4; i++)
        begin
            wr(OFS_CTRLB_SET, {27'h3, i[1:0], 3'h0});
            cyc(6);
            rd(OFS_STATUS);
            chk(v[ST_RAMP], i == 1);
            rd(OFS_CTRLB_SET);
            chk(v[4:3], 2'h0);
        end
        for (i = 1; i < 6; i++)
        begin
            wr(OFS_CTRLB_SET, {i[2:0], 5'h0});
            cyc(6);
            rd(OFS_CTRLB_SET);
            chk(v[7:5], 3'h0);
            rd(OFS_STATUS);
            chk(v[ST_STOP], i >= 2);
        end
        chk(dma_cnt, 1);
        wr(OFS_PRESCALE, 32'hff);
        wr(OFS_CTRLB_SET, 32'ha0);
        wr(OFS_CTRLB_CLEAR, 32'h00);
        rd(OFS_CTRLB_SET);
        chk(v[7:5], CMD_DMA_TRIGGER);
        wr(OFS_CTRLB_CLEAR, 32'h20);
        rd(OFS_CTRLB_SET);
        chk(v[7:5], 3'h0);
        cyc(600);
        chk(dma_cnt, 1);
        wr(OFS_PRESCALE, 32'h0);
        wr(OFS_PERIOD, 32'h10);
        wr(OFS_CTRLB_SET, 32'h24);
        cyc(90);
        rd(OFS_STATUS);
        chk(v[ST_STOP], 1'b1);
        wr(OFS_CTRLB_CLEAR, 32'h04);
        wr(OFS_CTRLB_SET, 32'h20);
        cyc(6);
        rd(OFS_STATUS);
        chk(v[ST_STOP], 1'b0);
        wr(OFS_FAULT_CTRL, HALT_SW);
        recov_fault_in <= 2'h1;
        cyc(8);
        recov_fault_in <= 2'h0;
        snap(a);
        snap(b);
        chk(b, a);
        wr(OFS_STATUS, 32'h1 << ST_RECOV0);
        wr(OFS_CTRLB_SET, 32'h20);
        snap(a);
        snap(b);
        chk(a === b, 1'b0);
        wr(OFS_DRIVER_CTRL, 32'h35f);
        wr(OFS_EVENT_CTRL, 32'hffffffff);
        nonrecov_fault_in <= 2'h2;
        cyc(1);
        nonrecov_fault_in <= 2'h0;
        cyc(6);
        rd(OFS_STATUS);
        chk(v[ST_NRF], 1'b0);
        nonrecov_fault_in <= 2'h2;
        cyc(30);
        chk(compare_out, 4'h5);
        chk(irq, 1'b0);
        wr(OFS_INT_MASK, 32'h8);
        cyc(2);
        chk(irq, 1'b1);
        nonrecov_fault_in <= 2'h0;
        cyc(8);
        wr(OFS_INT_STATUS, 32'h8);
        cyc(2);
        chk(irq, 1'b0);
        write_protect <= 1'b1;
        wr(OFS_CTRLB_SET, 32'h04);
        chk(resp, 2'h2);
        write_protect <= 1'b0;
        rd(OFS_CTRLB_SET);
        chk(v[CB_SINGLE_RUN], 1'b0);
        rd(8'h3c);
        chk({v, resp}, 34'h2);
        complete_run();
    end
endmodule : pwm_timer_command_and_fault_control_bench
`default_nettype wire
